//--- rtl/adcsf_regs.svh
// register offsets, field positions, reset values of the converter sequencer
// assumes a 32-bit apb slave with byte addresses, one word per register
`ifndef ADCSF_REGS_SVH
`define ADCSF_REGS_SVH

// ********************************************************
// offsets
// ********************************************************
`define ADCSF_OFF_CTRL   8'h00
`define ADCSF_OFF_STAT   8'h04
`define ADCSF_OFF_CNT    8'h08
`define ADCSF_OFF_FLTH   8'h0c
`define ADCSF_OFF_FLTL   8'h10
`define ADCSF_OFF_RES    8'h14
`define ADCSF_OFF_PREV   8'h18
`define ADCSF_OFF_ACC    8'h1c
`define ADCSF_OFF_ERR    8'h20
`define ADCSF_OFF_SETPT  8'h24
`define ADCSF_OFF_THRESH 8'h28
`define ADCSF_OFF_RPT    8'h2c

// ********************************************************
// control fields
// ********************************************************
`define ADCSF_CTRL_GO    0
`define ADCSF_CTRL_CONT  1
`define ADCSF_CTRL_SOI   2
`define ADCSF_CTRL_DSEN  3
`define ADCSF_CTRL_PSIS  4
`define ADCSF_CTRL_CALC  5
`define ADCSF_CTRL_MODE  8
`define ADCSF_CTRL_SHIFT 12

// ********************************************************
// status fields
// ********************************************************
`define ADCSF_STAT_GO    0
`define ADCSF_STAT_MRDY  1
`define ADCSF_STAT_TIF   2
`define ADCSF_STAT_HELD  3

// ********************************************************
// reset values and counter maximum
// ********************************************************
`define ADCSF_UPPER_RST  16'h7fff
`define ADCSF_LOWER_RST  16'h8000
`define ADCSF_RPT_RST    8'h01
`define ADCSF_SETPT_RST  16'h0000
`define ADCSF_CNT_MAX    8'hff

`endif

//--- rtl/adcsf_pkg.sv
// types shared by the converter sequencer and its filter
// assumes nothing beyond the header of constants
package adcsf_pkg;
  typedef enum logic [2:0] {
    ADCSF_BASIC,
    ADCSF_ACCUM,
    ADCSF_AVERAGE,
    ADCSF_BURST,
    ADCSF_LPF
  } adcsf_mode_e;

  typedef logic signed [15:0] adcsf_word_t;
endpackage

//--- rtl/adcsf_flt_if.sv
// carrier between the sequencer and the filter output module
// assumes both ends run on pclk
interface adcsf_flt_if #(
  parameter int ACC_W = 18
);
  logic                    sample_valid;
  logic signed [15:0]      sample;
  logic signed [ACC_W-1:0] acc;
  logic [2:0]              shift;
  logic                    lpf_mode;
  logic signed [15:0]      flt;

  modport seq  (output sample_valid, sample, acc, shift, lpf_mode, input flt);
  modport filt (input sample_valid, sample, acc, shift, lpf_mode, output flt);
endinterface

//--- rtl/adcsf_filter.sv
// filter output: shifted accumulator or low-pass filter state
// assumes the sequencer drives the carrier on the same clock
module adcsf_filter #(
  parameter int ACC_W = 18
) (
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, active low
  adcsf_flt_if.filt bus       // sequencer side
);
  import adcsf_pkg::*;

  adcsf_word_t             lpf_reg;
  adcsf_word_t             lpf_next;
  logic signed [16:0]      diff;
  logic signed [ACC_W-1:0] shifted;

  // ********************************************************
  // low-pass state
  // ********************************************************
  always_comb begin
    diff     = 17'(bus.sample) - 17'(lpf_reg);
    lpf_next = lpf_reg;
    if (bus.sample_valid && bus.lpf_mode) begin
      lpf_next = lpf_reg + 16'(diff >>> bus.shift);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpf_reg <= 16'sh0000;
    end else begin
      lpf_reg <= lpf_next;
    end
  end

  // ********************************************************
  // output select
  // ********************************************************
  always_comb begin
    shifted = bus.acc >>> bus.shift;
    bus.flt = bus.lpf_mode ? lpf_reg : shifted[15:0];
  end
endmodule

//--- rtl/adcsf_top.sv
// converter sequencing, double sampling, trigger counter and filter output
// assumes an apb master on pclk and a converter front end on the same clock
`include "adcsf_regs.svh"

// Function
// - continuous mode retriggers after each accumulator update
// - retrigger stops on reset or stop-on-interrupt
// - double sample needs two conversions before error
// - first conversion sets math-ready, updates accumulator only
// - second conversion moves previous and result values
// - error and threshold flag only after second
// - counter increments once per converter trigger
// - counter saturates at maximum, never wraps
// - in average, burst and low-pass modes counter decides when threshold is checked
// - filter output is accumulator shifted right
// - low-pass mode outputs low-pass filter result
// - filter output sixteen bits in two bytes
module adcsf_top #(
  parameter int DATA_W = 10,
  parameter int ACC_W  = 18
) (
  input  wire logic              pclk,        // system clock
  input  wire logic              presetn,     // async reset, active low
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb access phase
  input  wire logic              pwrite,      // apb direction
  input  wire logic [7:0]        paddr,       // apb byte address
  input  wire logic [31:0]       pwdata,      // apb write data
  output logic      [31:0]       prdata,      // apb read data
  output logic                   pready,      // apb ready
  output logic                   pslverr,     // apb error, unmapped
  input  wire logic              ext_trig,    // trigger pulse
  output logic                   conv_start,  // start one conversion
  input  wire logic              conv_done,   // conversion finished
  input  wire logic [DATA_W-1:0] conv_data,   // conversion value
  output logic                   thresh_flag  // threshold flag level
);
  import adcsf_pkg::*;

  // ********************************************************
  // address decode
  // ********************************************************
  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      `ADCSF_OFF_CTRL, `ADCSF_OFF_STAT, `ADCSF_OFF_CNT, `ADCSF_OFF_FLTH,
      `ADCSF_OFF_FLTL, `ADCSF_OFF_RES, `ADCSF_OFF_PREV, `ADCSF_OFF_ACC,
      `ADCSF_OFF_ERR, `ADCSF_OFF_SETPT, `ADCSF_OFF_THRESH, `ADCSF_OFF_RPT:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  adcsf_flt_if #(.ACC_W(ACC_W)) flt_if ();

  adcsf_filter #(.ACC_W(ACC_W)) i_adcsf_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (flt_if.filt)
  );

  // ********************************************************
  // state
  // ********************************************************
  logic                    cont_reg,   cont_next;
  logic                    soi_reg,    soi_next;
  logic                    dsen_reg,   dsen_next;
  logic                    psis_reg,   psis_next;
  logic [1:0]              calc_reg,   calc_next;
  logic [2:0]              mode_reg,   mode_next;
  logic [2:0]              shift_reg,  shift_next;
  logic                    go_reg,     go_next;
  logic                    start_reg,  start_next;
  logic                    mrdy_reg,   mrdy_next;
  logic                    tif_reg,    tif_next;
  logic                    held_reg,   held_next;
  logic [7:0]              cnt_reg,    cnt_next;
  logic signed [ACC_W-1:0] acc_reg,    acc_next;
  adcsf_word_t             res_reg,    res_next;
  adcsf_word_t             prev_reg,   prev_next;
  adcsf_word_t             first_reg,  first_next;
  adcsf_word_t             err_reg,    err_next;
  adcsf_word_t             setpt_reg,  setpt_next;
  adcsf_word_t             upper_reg,  upper_next;
  adcsf_word_t             lower_reg,  lower_next;
  logic [7:0]              rpt_reg,    rpt_next;
  logic [31:0]             rdata_reg,  rdata_next;

  logic                    wr;
  logic                    rd_setup;
  logic                    trig;
  logic                    done;
  logic                    compute;
  logic                    check;
  logic                    tif_set;
  logic                    retrig;
  logic                    windowed;
  adcsf_mode_e             mode;
  adcsf_word_t             sample;
  adcsf_word_t             prev_src;
  adcsf_word_t             err_new;
  logic signed [ACC_W-1:0] samp_acc;

  assign mode     = adcsf_mode_e'(mode_reg);
  assign sample   = 16'(conv_data);
  assign samp_acc = ACC_W'(conv_data);
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // ********************************************************
  // apb handshake
  // ********************************************************
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !is_mapped(paddr);
  assign prdata      = rdata_reg;
  assign conv_start  = start_reg;
  assign thresh_flag = tif_reg;

  assign flt_if.sample_valid = done;
  assign flt_if.sample       = sample;
  assign flt_if.acc          = acc_reg;
  assign flt_if.shift        = shift_reg;
  assign flt_if.lpf_mode     = (mode == ADCSF_LPF);

  // ********************************************************
  // sequencing
  // ********************************************************
  always_comb begin
    trig     = (ext_trig || (wr && paddr == `ADCSF_OFF_CTRL && pwdata[`ADCSF_CTRL_GO]))
               && !go_reg;
    done     = conv_done && go_reg;
    compute  = done && (!dsen_reg || held_reg);
    windowed = (mode == ADCSF_AVERAGE) || (mode == ADCSF_BURST) || (mode == ADCSF_LPF);
    check    = compute && (!windowed || cnt_reg >= rpt_reg);
    prev_src = psis_reg ? flt_if.flt : (dsen_reg ? first_reg : res_reg);
    unique case (calc_reg)
      2'h0:    err_new = sample - prev_src;
      2'h1:    err_new = sample - setpt_reg;
      default: err_new = flt_if.flt - setpt_reg;
    endcase
    tif_set  = check && (err_new > upper_reg || err_new < lower_reg);
    retrig   = done && cont_reg && !(soi_reg && (tif_set || tif_reg));

    go_next    = go_reg;
    start_next = trig || retrig;
    if (trig) begin
      go_next = 1'b1;
    end else if (done) begin
      go_next = retrig;
    end

    held_next = held_reg;
    if (!dsen_reg) begin
      held_next = 1'b0;
    end else if (done) begin
      held_next = !held_reg;
    end

    acc_next = acc_reg;
    if (done) begin
      unique case (mode)
        ADCSF_BASIC: acc_next = samp_acc;
        ADCSF_LPF:   acc_next = acc_reg - (acc_reg >>> shift_reg) + samp_acc;
        default:     acc_next = acc_reg + samp_acc;
      endcase
    end

    first_next = (done && dsen_reg && !held_reg) ? sample : first_reg;
    res_next   = compute ? sample : res_reg;
    prev_next  = compute ? prev_src : prev_reg;
    err_next   = compute ? err_new : err_reg;

    mrdy_next = mrdy_reg;
    if (done) begin
      mrdy_next = 1'b1;
    end else if (wr && paddr == `ADCSF_OFF_STAT && pwdata[`ADCSF_STAT_MRDY]) begin
      mrdy_next = 1'b0;
    end

    tif_next = tif_reg;
    if (tif_set) begin
      tif_next = 1'b1;
    end else if (wr && paddr == `ADCSF_OFF_STAT && pwdata[`ADCSF_STAT_TIF]) begin
      tif_next = 1'b0;
    end

    cnt_next = cnt_reg;
    if (wr && paddr == `ADCSF_OFF_CNT) begin
      cnt_next = pwdata[7:0];
    end else if ((trig || retrig) && cnt_reg != `ADCSF_CNT_MAX) begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  // ********************************************************
  // software registers
  // ********************************************************
  always_comb begin
    cont_next  = cont_reg;
    soi_next   = soi_reg;
    dsen_next  = dsen_reg;
    psis_next  = psis_reg;
    calc_next  = calc_reg;
    mode_next  = mode_reg;
    shift_next = shift_reg;
    setpt_next = setpt_reg;
    upper_next = upper_reg;
    lower_next = lower_reg;
    rpt_next   = rpt_reg;
    if (wr && paddr == `ADCSF_OFF_CTRL) begin
      cont_next  = pwdata[`ADCSF_CTRL_CONT];
      soi_next   = pwdata[`ADCSF_CTRL_SOI];
      dsen_next  = pwdata[`ADCSF_CTRL_DSEN];
      psis_next  = pwdata[`ADCSF_CTRL_PSIS];
      calc_next  = pwdata[`ADCSF_CTRL_CALC +: 2];
      mode_next  = (pwdata[`ADCSF_CTRL_MODE +: 3] > 3'h4) ? 3'h4 : pwdata[`ADCSF_CTRL_MODE +: 3];
      shift_next = pwdata[`ADCSF_CTRL_SHIFT +: 3];
    end
    if (wr && paddr == `ADCSF_OFF_SETPT) begin
      setpt_next = pwdata[15:0];
    end
    if (wr && paddr == `ADCSF_OFF_THRESH) begin
      upper_next = pwdata[15:0];
      lower_next = pwdata[31:16];
    end
    if (wr && paddr == `ADCSF_OFF_RPT) begin
      rpt_next = pwdata[7:0];
    end

    rdata_next = rdata_reg;
    if (rd_setup) begin
      rdata_next = 32'h0000_0000;
      if (is_mapped(paddr)) begin
        unique case (paddr)
          `ADCSF_OFF_CTRL:   rdata_next = {17'h0, shift_reg, 1'b0, mode_reg, 1'b0, calc_reg,
                                           psis_reg, dsen_reg, soi_reg, cont_reg, go_reg};
          `ADCSF_OFF_STAT:   rdata_next = {28'h0, held_reg, tif_reg, mrdy_reg, go_reg};
          `ADCSF_OFF_CNT:    rdata_next = {24'h0, cnt_reg};
          `ADCSF_OFF_FLTH:   rdata_next = {24'h0, flt_if.flt[15:8]};
          `ADCSF_OFF_FLTL:   rdata_next = {24'h0, flt_if.flt[7:0]};
          `ADCSF_OFF_RES:    rdata_next = {16'h0, res_reg};
          `ADCSF_OFF_PREV:   rdata_next = {16'h0, prev_reg};
          `ADCSF_OFF_ACC:    rdata_next = 32'(acc_reg);
          `ADCSF_OFF_ERR:    rdata_next = {16'h0, err_reg};
          `ADCSF_OFF_SETPT:  rdata_next = {16'h0, setpt_reg};
          `ADCSF_OFF_THRESH: rdata_next = {lower_reg, upper_reg};
          default:           rdata_next = {24'h0, rpt_reg};
        endcase
      end
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_reg  <= 1'b0;
      soi_reg   <= 1'b0;
      dsen_reg  <= 1'b0;
      psis_reg  <= 1'b0;
      calc_reg  <= 2'h0;
      mode_reg  <= 3'h0;
      shift_reg <= 3'h0;
      go_reg    <= 1'b0;
      start_reg <= 1'b0;
      mrdy_reg  <= 1'b0;
      tif_reg   <= 1'b0;
      held_reg  <= 1'b0;
      cnt_reg   <= 8'h00;
      acc_reg   <= '0;
      res_reg   <= 16'sh0000;
      prev_reg  <= 16'sh0000;
      first_reg <= 16'sh0000;
      err_reg   <= 16'sh0000;
      setpt_reg <= `ADCSF_SETPT_RST;
      upper_reg <= `ADCSF_UPPER_RST;
      lower_reg <= `ADCSF_LOWER_RST;
      rpt_reg   <= `ADCSF_RPT_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cont_reg  <= cont_next;
      soi_reg   <= soi_next;
      dsen_reg  <= dsen_next;
      psis_reg  <= psis_next;
      calc_reg  <= calc_next;
      mode_reg  <= mode_next;
      shift_reg <= shift_next;
      go_reg    <= go_next;
      start_reg <= start_next;
      mrdy_reg  <= mrdy_next;
      tif_reg   <= tif_next;
      held_reg  <= held_next;
      cnt_reg   <= cnt_next;
      acc_reg   <= acc_next;
      res_reg   <= res_next;
      prev_reg  <= prev_next;
      first_reg <= first_next;
      err_reg   <= err_next;
      setpt_reg <= setpt_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
      rpt_reg   <= rpt_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

//--- verif/adcsf_checker.sv
// port-level checks of the converter sequencer
// assumes the offsets and control fields of adcsf_regs.svh
`include "adcsf_regs.svh"
module adcsf_checker (
  input wire logic        pclk,        // system clock
  input wire logic        presetn,     // async reset, active low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb access phase
  input wire logic        pwrite,      // apb direction
  input wire logic [7:0]  paddr,       // apb byte address
  input wire logic [31:0] pwdata,      // apb write data
  input wire logic        ext_trig,    // trigger pulse
  input wire logic        conv_start,  // start one conversion
  input wire logic        conv_done,   // conversion finished
  input wire logic        thresh_flag  // threshold flag level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // shadow of control bits and conversion state
  // ********************************************************
  logic busy_reg, cont_reg, soi_reg, dsen_reg, half_reg, wr_ctrl, done_ok;
  assign wr_ctrl = psel && penable && pwrite && paddr == `ADCSF_OFF_CTRL;
  assign done_ok = conv_done && busy_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy_reg, cont_reg, soi_reg, dsen_reg, half_reg} <= 5'h00;
    end else begin
      busy_reg <= conv_start | (busy_reg & !conv_done);
      if (wr_ctrl) begin
        cont_reg <= pwdata[`ADCSF_CTRL_CONT];
        soi_reg  <= pwdata[`ADCSF_CTRL_SOI];
        dsen_reg <= pwdata[`ADCSF_CTRL_DSEN];
      end
      if (done_ok && dsen_reg) begin
        half_reg <= !half_reg;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_trig_starts: assert property (ext_trig && !busy_reg && !conv_start && !$past(conv_done)
    |=> conv_start) else $error("trigger gave no start");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_cause: assert property (conv_start |->
    $past(ext_trig || conv_done || (wr_ctrl && pwdata[`ADCSF_CTRL_GO])))
    else $error("start without cause");
  a_cont_retrig: assert property (done_ok && cont_reg && !soi_reg && !wr_ctrl
    |=> conv_start) else $error("no retrigger in continuous mode");
  a_no_retrig: assert property (done_ok && !cont_reg && !wr_ctrl |=> !conv_start)
    else $error("retrigger without continuous");
  a_soi_stops: assert property (done_ok && soi_reg && thresh_flag |=> !conv_start)
    else $error("retrigger despite stop on flag");
  a_first_quiet: assert property (done_ok && dsen_reg && !half_reg
    |=> !$rose(thresh_flag)) else $error("flag on first of pair");
  a_flag_cause: assert property ($rose(thresh_flag) |-> $past(conv_done))
    else $error("flag rose without conversion");
  c_retrig: cover property (done_ok && cont_reg ##1 conv_start);
  c_pair: cover property (done_ok && dsen_reg && half_reg);
  c_flag: cover property ($rose(thresh_flag));
endmodule

bind adcsf_top adcsf_checker i_adcsf_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ext_trig(ext_trig),
  .conv_start(conv_start), .conv_done(conv_done), .thresh_flag(thresh_flag));

//--- verif/tb_adcsf_top.sv
// self-checking bench of the converter sequencer and filter output
// assumes adcsf_top as apb slave and the checker bound from its own file
`include "adcsf_regs.svh"
module tb_adcsf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, ext_trig, conv_done;
  logic        pready, pslverr, conv_start, thresh_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  conv_data;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          seed = 80;
  int          sh, acc, st, d, e;
  adcsf_top i_adcsf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig(ext_trig), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .thresh_flag(thresh_flag));
  always #2 pclk = ~pclk;
  // ********************************************************
  // drivers
  // ********************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back({1'b0, x});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic fin(input logic [9:0] v);
    conv_done <= 1'b1;
    conv_data <= v;
    @(posedge pclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic cyc(input logic [9:0] v, input logic x);
    ext_trig <= 1'b1;
    @(posedge pclk);
    ext_trig <= x;
    @(posedge pclk);
    ext_trig <= 1'b0;
    fin(v);
  endtask
  task automatic reset_dut;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // read results compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_v = exp_q.pop_front();
      samples_checked++;
      if ({pslverr, prdata} !== exp_v) begin
        bad_count++;
        $display("MISMATCH %0t addr %h got %h exp %h", $time, paddr, {pslverr, prdata}, exp_v);
      end
    end
  end
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
  // ********************************************************
  // scenarios
  // ********************************************************
  initial begin
    {psel, penable, pwrite, ext_trig, conv_done, presetn} = 6'h00;
    {paddr, pwdata, conv_data} = '0;
    reset_dut();
    rd(`ADCSF_OFF_CNT, 32'h0);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h30, 32'h0);
    wr(`ADCSF_OFF_CNT, 32'hfd);
    cyc(10'h011, 1'b1);
    rd(`ADCSF_OFF_CNT, 32'hfe);
    cyc(10'h022, 1'b0);
    cyc(10'h033, 1'b0);
    rd(`ADCSF_OFF_CNT, 32'hff);
    $display("test counter done");
    wr(`ADCSF_OFF_CNT, 32'h0);
    wr(`ADCSF_OFF_CTRL, 32'h3);
    fin(10'h010);
    fin(10'h020);
    wr(`ADCSF_OFF_CTRL, 32'h0);
    fin(10'h030);
    rd(`ADCSF_OFF_CNT, 32'h3);
    rd(`ADCSF_OFF_STAT, 32'h2);
    $display("test continuous done");
    wr(`ADCSF_OFF_STAT, 32'h6);
    wr(`ADCSF_OFF_THRESH, 32'h8000_0010);
    wr(`ADCSF_OFF_CNT, 32'h0);
    wr(`ADCSF_OFF_CTRL, 32'h27);
    fin(10'h064);
    rd(`ADCSF_OFF_CNT, 32'h1);
    cyc(10'h064, 1'b0);
    rd(`ADCSF_OFF_CNT, 32'h2);
    rd(`ADCSF_OFF_STAT, 32'h6);
    $display("test stop on flag done");
    wr(`ADCSF_OFF_STAT, 32'h6);
    wr(`ADCSF_OFF_CTRL, 32'h28);
    cyc(10'h050, 1'b0);
    rd(`ADCSF_OFF_STAT, 32'ha);
    cyc(10'h060, 1'b0);
    rd(`ADCSF_OFF_PREV, 32'h50);
    rd(`ADCSF_OFF_RES, 32'h60);
    rd(`ADCSF_OFF_ERR, 32'h60);
    rd(`ADCSF_OFF_STAT, 32'h6);
    $display("test double sample done");
    wr(`ADCSF_OFF_STAT, 32'h6);
    wr(`ADCSF_OFF_RPT, 32'h2);
    wr(`ADCSF_OFF_CNT, 32'h0);
    wr(`ADCSF_OFF_CTRL, 32'h220);
    cyc(10'h064, 1'b0);
    rd(`ADCSF_OFF_STAT, 32'h2);
    cyc(10'h064, 1'b0);
    rd(`ADCSF_OFF_STAT, 32'h6);
    rd(`ADCSF_OFF_FLTH, 32'h01);
    rd(`ADCSF_OFF_FLTL, 32'h28);
    $display("test average window done");
    for (int i = 0; i < 4; i++) begin
      reset_dut();
      sh = $random(seed) & 7;
      acc = 0;
      st = 0;
      wr(`ADCSF_OFF_CTRL, (i < 2 ? 32'h100 : 32'h400) | (32'(sh) << 12));
      for (int k = 0; k < 2; k++) begin
        d = $random(seed) & 32'h3ff;
        acc += d;
        st += (d - st) >>> sh;
        cyc(d[9:0], 1'b0);
      end
      e = (i < 2) ? (acc >>> sh) : st;
      rd(`ADCSF_OFF_FLTH, {24'h0, e[15:8]});
      rd(`ADCSF_OFF_FLTL, {24'h0, e[7:0]});
    end
    $display("test filter output done");
    finish_test();
  end
endmodule
